// *** include/frame_sync_pkg.sv ***
// Constants for the frame sync alignment block
package frame_sync_pkg;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int MCLK_FREQ_HZ = 40000000;
   localparam int FRAME_RATE_HZ = 8000;
   localparam int FRAMES_PER_MULTI = 4;
   // One 8 kHz frame in mclk cycles
   localparam int FRAME_CYCLES = MCLK_FREQ_HZ / FRAME_RATE_HZ;
   // One 2 kHz multiframe in mclk cycles
   localparam int MULTI_CYCLES = FRAME_CYCLES * FRAMES_PER_MULTI;
   // Events closer than this are taken as 4 kHz or 8 kHz input
   localparam int MULTI_MIN_GAP = (MULTI_CYCLES * 3) / 4;

   // -----------------------------------------------------------------
   // Register map (byte offsets of the plain register port)
   // -----------------------------------------------------------------
   localparam logic [7:0] OUT_SOURCE_OFFSET = 8'h7a;
   localparam logic [7:0] SYNC_PHASE_OFFSET = 8'h7b;
   localparam logic [7:0] ALIGN_STATUS_OFFSET = 8'h7c;

   // Fields of the output source register
   localparam int AUX_SELECT_BIT = 7;
   // Fields of the sync phase register
   localparam int PHASE_SHIFT_LSB = 0;
   localparam int OPTICAL_SYNC_BIT = 6;
   localparam int INDEP_SYNC_BIT = 7;
   // Fields of the status register
   localparam int STAT_FRAME_BIT = 0;
   localparam int STAT_MULTI_BIT = 1;
   localparam int STAT_SHORT_BIT = 2;

   // Values after reset
   localparam logic AUX_SELECT_RESET = 1'b0;
   localparam logic [1:0] PHASE_SHIFT_RESET = 2'h0;
   localparam logic OPTICAL_SYNC_RESET = 1'b0;
   localparam logic INDEP_SYNC_RESET = 1'b0;

   // -----------------------------------------------------------------
   // Sampling
   // -----------------------------------------------------------------
   // Half reference cycles of input history kept for the phase shift
   localparam int HIST_DEPTH = 4;

   // Resolution grid used to quantise the alignment event
   typedef enum logic [1:0] {
      RES_6M48 = 2'b00,
      RES_19M44 = 2'b01,
      RES_38M88 = 2'b10
   } resolution_t;

endpackage

// *** rtl/frame_sync_align.sv ***
// Frame and multiframe pulse alignment to the external 2 kHz alignment input
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// - Only the falling alignment edge aligns.
// - 4 or 8 kHz input aligns frame only.
// - Sample with selected reference, rising edge default.
// - Two-bit field shifts expected arrival time.
// - Optical sync low gives 6.48 MHz resolution.
// - Optical sync high: 19.44 or 38.88 MHz.
// - Dependent mode keeps high-rate clocks aligned.
// - Dependent plus optical resyncs optical dividers.
// - Dependent optical resync may move 6.48 MHz phase.
// - Independent mode realigns only the sync pulses.
// - 19.44 MHz reference, both bits: align 19.44 only; code fires neither resync strobe.
// - Dedicated pulses always from primary path.
// - Source bit picks main output copy path.
module frame_sync_align
   import frame_sync_pkg::*;
#(
   parameter int MULTI_PERIOD = MULTI_CYCLES
) (
   // Clocking and reset
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clkEn,
   // Pins from the master and reference selector
   input wire logic frameAlignInput,
   input wire logic refClkSel,
   input wire logic ref19m44Locked,
   // Resolution grid ticks from the primary path
   input wire logic tick6m48,
   input wire logic tick19m44,
   input wire logic tick38m88,
   // Auxiliary path sync copies
   input wire logic auxFrame8k,
   input wire logic auxMulti2k,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   // Sync outputs
   output logic framePulse8k,
   output logic multiframePulse2k,
   output logic mainCopy8k,
   output logic mainCopy2k,
   // Divider resync strobes to the clock generators
   output logic hiRateResync,
   output logic opticalResync
);

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   logic alignSync;
   logic refSync;
   logic ref19Sync;

   sync_2ff #(
      .WIDTH(3)
   ) u_pinSync (
      .mclk(mclk),
      .reset_n(reset_n),
      .clkEn(clkEn),
      .asyncIn({frameAlignInput, refClkSel, ref19m44Locked}),
      .syncOut({alignSync, refSync, ref19Sync})
   );

   // -----------------------------------------------------------------
   // Configuration registers
   // -----------------------------------------------------------------
   logic auxSelect_q;
   logic auxSelect_d;
   logic [1:0] phaseShift_q;
   logic [1:0] phaseShift_d;
   logic opticalSync_q;
   logic opticalSync_d;
   logic indepSync_q;
   logic indepSync_d;
   logic [7:0] rdData_q;
   logic [7:0] rdData_d;
   logic seenFrame_q;
   logic seenMulti_q;
   logic seenShort_q;

   // Writes land on the addressed register; reads answer next cycle
   always_comb begin
      auxSelect_d = auxSelect_q;
      phaseShift_d = phaseShift_q;
      opticalSync_d = opticalSync_q;
      indepSync_d = indepSync_q;
      rdData_d = '0;
      if (clkEn && regWrite) begin
         unique case (regAddr)
            OUT_SOURCE_OFFSET: begin
               auxSelect_d = regWrData[AUX_SELECT_BIT];
            end
            SYNC_PHASE_OFFSET: begin
               phaseShift_d = regWrData[PHASE_SHIFT_LSB+:2];
               opticalSync_d = regWrData[OPTICAL_SYNC_BIT];
               indepSync_d = regWrData[INDEP_SYNC_BIT];
            end
            default: begin
               auxSelect_d = auxSelect_q;
            end
         endcase
      end
      if (clkEn && regRead) begin
         unique case (regAddr)
            OUT_SOURCE_OFFSET: begin
               rdData_d[AUX_SELECT_BIT] = auxSelect_q;
            end
            SYNC_PHASE_OFFSET: begin
               rdData_d[PHASE_SHIFT_LSB+:2] = phaseShift_q;
               rdData_d[OPTICAL_SYNC_BIT] = opticalSync_q;
               rdData_d[INDEP_SYNC_BIT] = indepSync_q;
            end
            ALIGN_STATUS_OFFSET: begin
               rdData_d[STAT_FRAME_BIT] = seenFrame_q;
               rdData_d[STAT_MULTI_BIT] = seenMulti_q;
               rdData_d[STAT_SHORT_BIT] = seenShort_q;
            end
            default: begin
               rdData_d = '0; // Unmapped reads return zero
            end
         endcase
      end else if (!clkEn) begin
         rdData_d = rdData_q;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         auxSelect_q <= AUX_SELECT_RESET;
         phaseShift_q <= PHASE_SHIFT_RESET;
         opticalSync_q <= OPTICAL_SYNC_RESET;
         indepSync_q <= INDEP_SYNC_RESET;
         rdData_q <= '0;
      end else begin
         auxSelect_q <= auxSelect_d;
         phaseShift_q <= phaseShift_d;
         opticalSync_q <= opticalSync_d;
         indepSync_q <= indepSync_d;
         rdData_q <= rdData_d;
      end
   end

   // -----------------------------------------------------------------
   // Sampling on the selected reference clock
   // -----------------------------------------------------------------
   logic refPrev_q;
   logic refPrev_d;
   logic [HIST_DEPTH-1:0] hist_q;
   logic [HIST_DEPTH-1:0] hist_d;
   logic sampled_q;
   logic sampled_d;
   logic pending_q;
   logic pending_d;
   logic refEdge;
   logic refRise;
   logic [1:0] tapIdx;
   logic fallSeen;
   logic gridTick;

   // History holds the input at each reference half cycle so a late
   // or early arrival can be compensated without a faster clock
   assign refEdge = refSync ^ refPrev_q;
   assign refRise = refSync & ~refPrev_q;

   // Nominal tap is one cycle back; code 1 is half early,
   // codes 2 and 3 are half and one cycle late
   always_comb begin
      unique case (phaseShift_q)
         2'h0: tapIdx = 2'h1;
         2'h1: tapIdx = 2'h0;
         2'h2: tapIdx = 2'h2;
         2'h3: tapIdx = 2'h3;
      endcase
   end

   // Only a high to low change of the sampled input counts
   assign fallSeen = refRise && sampled_q && !hist_q[tapIdx];

   always_comb begin
      refPrev_d = refPrev_q;
      hist_d = hist_q;
      sampled_d = sampled_q;
      pending_d = pending_q;
      if (clkEn) begin
         refPrev_d = refSync;
         if (refEdge) begin
            hist_d = {hist_q[HIST_DEPTH-2:0], alignSync};
         end
         if (refRise) begin
            sampled_d = hist_q[tapIdx];
         end
         if (fallSeen) begin
            pending_d = 1'b1;
         end else if (gridTick) begin
            pending_d = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         refPrev_q <= 1'b0;
         hist_q <= '1;
         sampled_q <= 1'b1;
         pending_q <= 1'b0;
      end else begin
         refPrev_q <= refPrev_d;
         hist_q <= hist_d;
         sampled_q <= sampled_d;
         pending_q <= pending_d;
      end
   end

   // -----------------------------------------------------------------
   // Resolution grid
   // -----------------------------------------------------------------
   resolution_t resolution;
   logic alignEvent;

   // The event is snapped to the chosen grid; a coarser grid gives
   // more sampling margin at the cost of placement precision
   always_comb begin
      if (!opticalSync_q) begin
         resolution = RES_6M48;
      end else if (ref19Sync) begin
         resolution = RES_19M44;
      end else begin
         resolution = RES_38M88;
      end
      unique case (resolution)
         RES_6M48: gridTick = tick6m48;
         RES_19M44: gridTick = tick19m44;
         default: gridTick = tick38m88;
      endcase
   end

   assign alignEvent = pending_q && gridTick;

   // -----------------------------------------------------------------
   // Event spacing: a short gap means a 4 kHz or 8 kHz input
   // -----------------------------------------------------------------
   logic [15:0] gap_q;
   logic [15:0] gap_d;
   logic longGap;

   assign longGap = (gap_q >= 16'(MULTI_MIN_GAP));

   always_comb begin
      gap_d = gap_q;
      if (clkEn) begin
         if (alignEvent) begin
            gap_d = '0;
         end else if (!longGap) begin
            gap_d = gap_q + 16'h0001;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         gap_q <= 16'(MULTI_MIN_GAP);
      end else begin
         gap_q <= gap_d;
      end
   end

   // -----------------------------------------------------------------
   // Primary path pulse dividers
   // -----------------------------------------------------------------
   logic frameRestart;
   logic multiRestart;
   logic frameWrap;
   logic frameLow;
   logic multiLow;

   // A fast input only realigns the frame; the multiframe phase would
   // otherwise jump every few frames
   assign frameRestart = alignEvent;
   assign multiRestart = alignEvent && longGap;

   pulse_divider #(
      .WIDTH(16),
      .PERIOD(FRAME_CYCLES)
   ) u_frameDiv (
      .mclk(mclk),
      .reset_n(reset_n),
      .clkEn(clkEn),
      .advance(1'b1),
      .restart(frameRestart),
      .wrap(frameWrap),
      .pulseLow(frameLow)
   );

   pulse_divider #(
      .WIDTH(3),
      .PERIOD(MULTI_PERIOD / FRAME_CYCLES)
   ) u_multiDiv (
      .mclk(mclk),
      .reset_n(reset_n),
      .clkEn(clkEn),
      .advance(frameWrap),
      .restart(multiRestart),
      .wrap(),
      .pulseLow(multiLow)
   );

   // -----------------------------------------------------------------
   // Outputs and status
   // -----------------------------------------------------------------
   logic frame8k_q;
   logic frame8k_d;
   logic multi2k_q;
   logic multi2k_d;
   logic copy8k_q;
   logic copy8k_d;
   logic copy2k_q;
   logic copy2k_d;
   logic hiResync_q;
   logic hiResync_d;
   logic optResync_q;
   logic optResync_d;
   logic seenFrame_d;
   logic seenMulti_d;
   logic seenShort_d;

   always_comb begin
      frame8k_d = frame8k_q;
      multi2k_d = multi2k_q;
      copy8k_d = copy8k_q;
      copy2k_d = copy2k_q;
      hiResync_d = hiResync_q;
      optResync_d = optResync_q;
      seenFrame_d = seenFrame_q;
      seenMulti_d = seenMulti_q;
      seenShort_d = seenShort_q;
      if (clkEn) begin
         // Dedicated pulses never follow the auxiliary path
         frame8k_d = ~frameLow;
         multi2k_d = ~(multiLow && frameLow);
         if (auxSelect_q) begin
            copy8k_d = auxFrame8k;
            copy2k_d = auxMulti2k;
         end else begin
            copy8k_d = ~frameLow;
            copy2k_d = ~(multiLow && frameLow);
         end
         // Independent mode leaves every other output clock alone
         hiResync_d = alignEvent && !indepSync_q;
         // Optical dividers follow too, which can move the 6.48 MHz
         // output when the grid is finer than its period
         optResync_d = alignEvent && !indepSync_q && opticalSync_q;
         seenFrame_d = seenFrame_q || frameRestart;
         seenMulti_d = seenMulti_q || multiRestart;
         seenShort_d = seenShort_q || (alignEvent && !longGap);
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         frame8k_q <= 1'b1;
         multi2k_q <= 1'b1;
         copy8k_q <= 1'b1;
         copy2k_q <= 1'b1;
         hiResync_q <= 1'b0;
         optResync_q <= 1'b0;
         seenFrame_q <= 1'b0;
         seenMulti_q <= 1'b0;
         seenShort_q <= 1'b0;
      end else begin
         frame8k_q <= frame8k_d;
         multi2k_q <= multi2k_d;
         copy8k_q <= copy8k_d;
         copy2k_q <= copy2k_d;
         hiResync_q <= hiResync_d;
         optResync_q <= optResync_d;
         seenFrame_q <= seenFrame_d;
         seenMulti_q <= seenMulti_d;
         seenShort_q <= seenShort_d;
      end
   end

   assign regRdData = rdData_q;
   assign framePulse8k = frame8k_q;
   assign multiframePulse2k = multi2k_q;
   assign mainCopy8k = copy8k_q;
   assign mainCopy2k = copy2k_q;
   assign hiRateResync = hiResync_q;
   assign opticalResync = optResync_q;

endmodule
`default_nettype wire

// *** rtl/pulse_divider.sv ***
// Restartable modulo counter with a half-period low pulse
`timescale 1ns/1ps
`default_nettype none
module pulse_divider #(
   parameter int WIDTH = 16,
   parameter int PERIOD = 5000
) (
   // Clocking
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clkEn,
   // Control
   input wire logic advance,
   input wire logic restart,
   // Status
   output logic wrap,
   output logic pulseLow
);

   localparam logic [WIDTH-1:0] LAST = WIDTH'(PERIOD - 1);
   localparam logic [WIDTH-1:0] HALF = WIDTH'(PERIOD / 2);

   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;

   // Restart puts the count at zero, which is where the output falls
   always_comb begin
      count_d = count_q;
      if (clkEn) begin
         if (restart) begin
            count_d = '0;
         end else if (advance) begin
            count_d = (count_q == LAST) ? '0 : count_q + WIDTH'(1);
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

   assign wrap = advance && !restart && (count_q == LAST);
   assign pulseLow = (count_q < HALF);

endmodule
`default_nettype wire

// *** rtl/sync_2ff.sv ***
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
   parameter int WIDTH = 1
) (
   // Clocking
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clkEn,
   // Data
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // First stage is read only by the second stage
   always_comb begin
      meta_d = clkEn ? asyncIn : meta_q;
      sync_d = clkEn ? meta_q : sync_q;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign syncOut = sync_q;

endmodule
`default_nettype wire

// *** tb/frame_sync_align_props.sv ***
// Concurrent checks on the frame sync alignment ports
`timescale 1ns/1ps
`default_nettype none
module frame_sync_align_props
   import frame_sync_pkg::*;
#(
   parameter int MULTI_PERIOD = MULTI_CYCLES
) (
   // Clocking
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clkEn,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regRdData,
   // Sync side
   input wire logic auxFrame8k,
   input wire logic framePulse8k,
   input wire logic multiframePulse2k,
   input wire logic mainCopy8k,
   input wire logic hiRateResync,
   input wire logic opticalResync
);
   logic [7:0] phaseCfg_q;
   logic [7:0] phaseCfg_d;
   logic auxSel_q;
   logic auxSel_d;
   // Shadow copies of the writable registers, reserved bits dropped
   always_comb begin
      phaseCfg_d = phaseCfg_q;
      auxSel_d = auxSel_q;
      if (regWrite && clkEn && regAddr == SYNC_PHASE_OFFSET) begin
         phaseCfg_d = regWrData & 8'hc3;
      end
      if (regWrite && clkEn && regAddr == OUT_SOURCE_OFFSET) begin
         auxSel_d = regWrData[AUX_SELECT_BIT];
      end
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         phaseCfg_q <= 8'h00;
         auxSel_q <= 1'b0;
      end else begin
         phaseCfg_q <= phaseCfg_d;
         auxSel_q <= auxSel_d;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   a_resync_frame_low:
      assert property (hiRateResync |-> ##[0:1] !framePulse8k) else $error("frame did not follow resync");
   a_optical_with_hirate:
      assert property (opticalResync |-> hiRateResync) else $error("optical resync alone");
   a_indep_quiet:
      assert property (phaseCfg_q[INDEP_SYNC_BIT] && $past(phaseCfg_q[INDEP_SYNC_BIT], 2) |-> !hiRateResync)
      else $error("resync in independent mode");
   a_optical_gate:
      assert property (!phaseCfg_q[OPTICAL_SYNC_BIT] && !$past(phaseCfg_q[OPTICAL_SYNC_BIT], 2) |-> !opticalResync)
      else $error("optical resync while optical sync off");
   a_multi_in_frame:
      assert property (!multiframePulse2k |-> !framePulse8k) else $error("multiframe low outside frame low");
   a_strobe_single:
      assert property (hiRateResync |=> !hiRateResync) else $error("resync strobe too long");
   a_read_phase:
      assert property ($past(regRead && regAddr == SYNC_PHASE_OFFSET) |-> regRdData == $past(phaseCfg_q))
      else $error("phase register readback wrong");
   a_read_source:
      assert property ($past(regRead && regAddr == OUT_SOURCE_OFFSET) |-> regRdData == {$past(auxSel_q), 7'h00})
      else $error("source register readback wrong");
   a_copy_aux:
      assert property (auxSel_q && $past(auxSel_q) |-> mainCopy8k == $past(auxFrame8k))
      else $error("main copy not from auxiliary path");
endmodule
bind frame_sync_align frame_sync_align_props #(.MULTI_PERIOD(MULTI_PERIOD)) u_props (
   .mclk(mclk), .reset_n(reset_n), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
   .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .auxFrame8k(auxFrame8k),
   .framePulse8k(framePulse8k), .multiframePulse2k(multiframePulse2k), .mainCopy8k(mainCopy8k),
   .hiRateResync(hiRateResync), .opticalResync(opticalResync));
`default_nettype wire

// *** tb/master_model.sv ***
// Behavioural master timing device: reference clock and alignment input
`timescale 1ns/1ps
`default_nettype none
module master_model (
   // Control from the bench
   input wire logic run,
   input wire logic [15:0] gapRef,
   // Pins towards the slave
   output logic refClk,
   output logic syncOut
);
   // Free-running 6.67 MHz reference with no phase steps
   initial begin
      refClk = 1'b0;
      forever #75 refClk = ~refClk;
   end
   // Sync falls on a reference falling edge, leaving the rising sample mid-cycle
   initial begin
      syncOut = 1'b1;
      forever begin
         @(negedge refClk);
         if (run) begin
            syncOut <= 1'b0;
            repeat (16) @(negedge refClk);
            syncOut <= 1'b1;
            for (int i = 17; i < gapRef && run; i++) begin
               @(negedge refClk);
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the frame sync alignment block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import frame_sync_pkg::*;
   typedef struct packed {
      logic [7:0] cfg;
      logic locked;
      logic expHr;
      logic expOp;
   } row_t;
   // Phase codes, resolution grids and independent modes
   row_t rows [8] = '{
      '{8'h00, 1'b0, 1'b1, 1'b0},
      '{8'h01, 1'b0, 1'b1, 1'b0},
      '{8'h02, 1'b0, 1'b1, 1'b0},
      '{8'h03, 1'b0, 1'b1, 1'b0},
      '{8'h40, 1'b1, 1'b1, 1'b1},
      '{8'h40, 1'b0, 1'b1, 1'b1},
      '{8'h80, 1'b0, 1'b0, 1'b0},
      '{8'hc0, 1'b1, 1'b0, 1'b0}};
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic clkEn = 1'b1;
   logic run = 1'b0;
   logic [15:0] gapRef = 16'd3333;
   logic ref19m44Locked = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] cnt = 8'h00;
   logic tick6m48 = 1'b0;
   logic tick19m44 = 1'b0;
   logic tick38m88 = 1'b0;
   logic auxFrame8k = 1'b0;
   logic auxMulti2k = 1'b0;
   logic refClkSel;
   logic frameAlignInput;
   logic [7:0] regRdData;
   logic framePulse8k;
   logic multiframePulse2k;
   logic mainCopy8k;
   logic mainCopy2k;
   logic hiRateResync;
   logic opticalResync;
   int nFail = 0;
   int samplesChecked = 0;
   always #12.5 mclk = ~mclk;
   // Grid ticks and auxiliary copies, approximate rates are enough here
   always @(posedge mclk) begin
      cnt <= cnt + 8'h01;
      tick6m48 <= (cnt % 6) == 0;
      tick19m44 <= cnt[0];
      tick38m88 <= cnt[4:0] != 5'h00;
      auxFrame8k <= cnt[4];
      auxMulti2k <= cnt[6];
   end
   master_model partner (.run(run), .gapRef(gapRef), .refClk(refClkSel), .syncOut(frameAlignInput));
   frame_sync_align uut (.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn), .frameAlignInput(frameAlignInput),
      .refClkSel(refClkSel), .ref19m44Locked(ref19m44Locked), .tick6m48(tick6m48), .tick19m44(tick19m44),
      .tick38m88(tick38m88), .auxFrame8k(auxFrame8k), .auxMulti2k(auxMulti2k), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .framePulse8k(framePulse8k), .multiframePulse2k(multiframePulse2k), .mainCopy8k(mainCopy8k),
      .mainCopy2k(mainCopy2k), .hiRateResync(hiRateResync), .opticalResync(opticalResync));
   task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
      samplesChecked++;
      if (g !== e) begin
         nFail++;
         $display("[ERR] %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      #1 d = regRdData;
   endtask
   task automatic span(input logic lvl, output int n);
      n = 0;
      while (framePulse8k === lvl && n < 9000) begin
         @(posedge mclk);
         #1 n++;
      end
   endtask
   // Start at a frame rise so the restart shows as a fresh falling edge
   task automatic align(output int lat, output logic hr, output logic op, output logic mf);
      wait (framePulse8k === 1'b0);
      wait (framePulse8k === 1'b1);
      @(posedge mclk);
      run <= 1'b1;
      @(negedge frameAlignInput);
      lat = 0;
      hr = 1'b0;
      op = 1'b0;
      while (framePulse8k === 1'b1 && lat < 100) begin
         @(posedge mclk);
         #1 lat++;
         hr = hr | hiRateResync;
         op = op | opticalResync;
      end
      mf = multiframePulse2k;
      run <= 1'b0;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", samplesChecked, nFail);
      if (nFail == 0 && samplesChecked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (80000) @(posedge mclk);
      nFail++;
      summarize();
   end
   initial begin
      int lat;
      int lo;
      int hi;
      logic hr;
      logic op;
      logic mf;
      logic a;
      logic [7:0] d;
      repeat (8) @(posedge mclk);
      #1 chk("frame in reset", 16'h1, 16'(framePulse8k));
      chk("resync in reset", 16'h0, 16'(hiRateResync));
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      rd(ALIGN_STATUS_OFFSET, d);
      chk("status idle", 16'h0, 16'(d));
      wr(OUT_SOURCE_OFFSET, 8'hff);
      rd(OUT_SOURCE_OFFSET, d);
      chk("source reg", 16'h80, 16'(d));
      // Long enough for both auxiliary levels to show on both copies
      repeat (130) begin
         @(posedge mclk);
         a = auxFrame8k;
         mf = auxMulti2k;
         #1 chk("copy8k aux", 16'(a), 16'(mainCopy8k));
         chk("copy2k aux", 16'(mf), 16'(mainCopy2k));
      end
      wr(OUT_SOURCE_OFFSET, 8'h00);
      wr(SYNC_PHASE_OFFSET, 8'hff);
      rd(SYNC_PHASE_OFFSET, d);
      chk("phase reg", 16'hc3, 16'(d));
      wr(8'h55, 8'hff);
      rd(8'h55, d);
      chk("unmapped", 16'h0, 16'(d));
      wr(SYNC_PHASE_OFFSET, 8'h00);
      // First event after reset realigns frame and multiframe
      align(lat, hr, op, mf);
      chk("multi aligned", 16'h0, 16'(mf));
      span(1'b0, lo);
      span(1'b1, hi);
      chk("frame low", 16'(FRAME_CYCLES / 2), 16'(lo));
      chk("frame high", 16'(FRAME_CYCLES - FRAME_CYCLES / 2), 16'(hi));
      chk("copy8k primary", 16'h0, 16'(mainCopy8k));
      rd(ALIGN_STATUS_OFFSET, d);
      chk("status long", 16'h3, 16'(d));
      for (int i = 0; i < 8; i++) begin
         wr(SYNC_PHASE_OFFSET, rows[i].cfg);
         ref19m44Locked <= rows[i].locked;
         align(lat, hr, op, mf);
         chk("fall latency", 16'h1, 16'(lat >= 2 && lat <= 40));
         chk("hi rate resync", 16'(rows[i].expHr), 16'(hr));
         chk("optical resync", 16'(rows[i].expOp), 16'(op));
      end
      // An 8 kHz input keeps pulling the frame in, period below free run;
      // the fine grid keeps the snap jitter to one cycle
      wr(SYNC_PHASE_OFFSET, 8'h40);
      gapRef <= 16'd833;
      run <= 1'b1;
      repeat (12000) @(posedge mclk);
      wait (framePulse8k === 1'b1);
      @(negedge framePulse8k);
      #1 span(1'b0, lo);
      span(1'b1, hi);
      chk("short period", 16'h1, 16'(lo + hi > 4980 && lo + hi < 5000));
      run <= 1'b0;
      rd(ALIGN_STATUS_OFFSET, d);
      chk("status short", 16'h7, 16'(d));
      // A low enable must freeze the dividers for longer than a half frame
      @(posedge mclk);
      clkEn <= 1'b0;
      #1 a = framePulse8k;
      repeat (3000) @(posedge mclk);
      #1 chk("frozen frame", 16'(a), 16'(framePulse8k));
      @(posedge mclk);
      clkEn <= 1'b1;
      summarize();
   end
endmodule
`default_nettype wire
